// ### common/srp_pkg.sv
package srp_pkg;

  // Command opcodes recognised by this block.
  localparam logic [7:0] OP_RDSEC = 8'h48;
  localparam logic [7:0] OP_SETP = 8'h39;
  localparam logic [7:0] OP_RDS3 = 8'h33;

  // Bit counts of the command phases, less one, as the counters see them.
  localparam logic [4:0] OP_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h17;
  localparam logic [4:0] DUMMY_LAST = 5'h07;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Highest array address for each density.
  localparam logic [23:0] AMAX_LG = 24'h7fffff;
  localparam logic [23:0] AMAX_SM = 24'h3fffff;

  // Pointer word holds address bits 23..10; these are its field positions.
  localparam int PF_MODE = 0;
  localparam int PF_ALL = 1;
  localparam int PF_SEC_LSB = 2;
  localparam int PF_SEC_MSB = 12;
  localparam int PF_A22 = 12;
  localparam int PF_A23 = 13;
  localparam int ADDR_PTR_LSB = 10;

  // Delivered state of the pointer word: block protection chosen.
  localparam logic [13:0] PTR_RST = 14'h0001;

  // Erased byte value and an undefined-byte fill.
  localparam logic [7:0] ERASED = 8'hff;

  // Security register array: four registers of 256 bytes.
  localparam int SEC_AW = 10;
  localparam int SEC_DW = 8;

  // Self-timed pointer write cycle; no figure is printed, so this is plain.
  localparam int CLK_MHZ = 250;
  localparam int PROG_NS = 1000;
  localparam int PROG_CYC = (PROG_NS * CLK_MHZ) / 1000;

  // Serial command sequencer states, one-hot.
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_CMD = 8'h02,
    S_ADDR = 8'h04,
    S_DUMMY = 8'h08,
    S_DATA = 8'h10,
    S_STAT = 8'h20,
    S_HOLD = 8'h40,
    S_SKIP = 8'h80
  } srp_state_e;

endpackage

// ### verilog/srp_sync.sv
`timescale 1ns/10ps
`default_nettype none

module srp_sync
  import srp_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
  } srp_sync_s;

  srp_sync_s r_q;
  srp_sync_s r_d;

  // The first stage feeds only the second, so metastability never reaches logic.
  always_comb begin
    r_d.f1 = d;
    r_d.f2 = r_q.f1;
  end

  // Resets to all ones so idle-high pins look idle.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r_q <= '1;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.f2;

endmodule

`default_nettype wire

// ### verilog/srp_mem.sv
`timescale 1ns/10ps
`default_nettype none

module srp_mem
  import srp_pkg::*;
#(
  parameter int AW = SEC_AW,
  parameter int DW = SEC_DW
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  // Delivered state: every byte erased; set at declaration so only the clocked process writes the array.
  logic [DW-1:0] mem [2**AW] = '{default: DW'(ERASED)}; // RL20

  // Registered read; the array has no reset because it models non-volatile cells.
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

`default_nettype wire

// ### verilog/srp_top.sv
// Functional notes
// (RL1) Host reads a security register: opcode 48h, 24 address bits, eight dummy clocks.
// (RL2) Opcode and address bits are taken on each rising serial clock edge.
// (RL3) Read data goes out MSB first, changing on falling serial clock edges.
// (RL4) Address bits 23..16 nonzero give undefined data; not checked.
// (RL5) Byte address increments after each byte and wraps FFh to 00h.
// (RL6) Raising chip select ends a command and releases the output.
// (RL7) A security register read during a busy cycle is ignored entirely.
// (RL8) Address bits 15..8 pick the register; bits 7..0 pick the byte.
// (RL9) Host issues write enable before 39h; one protection scheme at a time.
// (RL10) 39h address bit 10 one picks block protection, zero picks pointer.
// (RL11) Pointer kept from bits 21..12 small density, 22..12 large density.
// (RL12) Pointer scheme with bit 11 set protects every sector.
// (RL13) The unprotected region always holds the whole sector with the pointer.
// (RL14) top_bottom_select zero unprotects from zero up; one from top down.
// (RL15) 39h is ignored while the status-protect bits lock the status registers.
// (RL16) 39h is ignored during an erase or program suspend.
// (RL17) 33h returns status register three, pointer high byte, pointer low byte.
// (RL18) Block erase over the pointer block refused except at the sector extremes.
// (RL19) Protection range is bounded by the highest array address per density.
// (RL20) Security registers and array start fully erased to FFh.
// (RL21) Busy reads one while a self-timed cycle runs.
// (RL22) Protection change is accepted only with the write enable latch set.
// (RL23) Accepted pointer steers later protection checks and survives power cycles.
`timescale 1ns/10ps
`default_nettype none

module srp_top
  import srp_pkg::*;
#(
  parameter logic LARGE = 1'b1,
  parameter logic [15:0] PROG_CYCLES = 16'(PROG_CYC)
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe_n,
  input wire logic busy_in,
  input wire logic suspend,
  input wire logic write_enable_latch,
  input wire logic status_protect_low,
  input wire logic status_protect_high,
  input wire logic top_bottom_select,
  input wire logic [7:0] status_reg_three,
  input wire logic blk_protect,
  input wire logic [23:0] chk_addr,
  input wire logic chk_block_erase,
  output logic chk_protected,
  input wire logic [13:0] nv_ptr,
  output logic [13:0] ptr_word,
  output logic nv_wr,
  output logic wel_clr,
  output logic busy,
  input wire logic sec_wr_en,
  input wire logic [SEC_AW-1:0] sec_wr_addr,
  input wire logic [SEC_DW-1:0] sec_wr_data
);

  typedef struct packed {
    srp_state_e st;
    logic sclk_p;
    logic [4:0] cnt;
    logic [7:0] op;
    logic [23:0] sh;
    logic [7:0] tx;
    logic so;
    logic oe_n;
    logic [1:0] sel;
    logic [7:0] byte_a;
    logic [1:0] pend;
    logic [1:0] sb;
    logic [13:0] ptr;
    logic boot;
    logic [15:0] prog;
    logic busy;
    logic wel_clr;
    logic nv_wr;
    logic prot;
  } srp_reg_s;

  localparam srp_reg_s REG_RST = '{
    st: S_IDLE,
    // Matches the synchroniser's reset level so no false rising edge follows reset.
    sclk_p: 1'b1,
    cnt: 5'h00,
    op: 8'h00,
    sh: 24'h000000,
    tx: ERASED,
    so: 1'b1,
    oe_n: 1'b1,
    sel: 2'h0,
    byte_a: 8'h00,
    pend: 2'h0,
    sb: 2'h0,
    ptr: PTR_RST,
    boot: 1'b1,
    prog: 16'h0000,
    busy: 1'b0,
    wel_clr: 1'b0,
    nv_wr: 1'b0,
    prot: 1'b0
  };

  srp_reg_s r_q;
  srp_reg_s r_d;

  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic wp_n_s;
  logic rise;
  logic fall;
  logic [23:0] addr_full;
  logic [23:0] amax;
  logic [23:0] ca;
  logic [10:0] sec;
  logic locked;
  logic commit_ok;
  logic [SEC_DW-1:0] rdata;

  // Register select from address bits 13..12 of the 15..8 field; 00h,10h,20h,30h map to 0..3.
  function automatic logic [1:0] sec_sel(input logic [23:0] a);
    return a[13:12]; // RL8
  endfunction

  // A sector is protected when it lies on the far side of the pointer sector.
  function automatic logic beyond(input logic [10:0] s, input logic [10:0] p, input logic tb);
    return tb ? (s < p) : (s > p); // RL14
  endfunction

  // Keep only the pointer bits that the density uses.
  function automatic logic [13:0] ptr_mask(input logic [13:0] v);
    logic [13:0] m;
    m = v;
    m[PF_A23] = 1'b0; // RL11
    if (!LARGE) begin
      m[PF_A22] = 1'b0; // RL11
    end
    return m;
  endfunction

  // Every host-side pin (cs_n, sclk, si, wp_n) is foreign to mclk, so all four pass two flops first.
  srp_sync #(
    .W(4)
  ) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .d({cs_n, sclk, si, wp_n}),
    .q({cs_n_s, sclk_s, si_s, wp_n_s})
  );

  // Security register bytes; delivered erased.
  srp_mem #(
    .AW(SEC_AW),
    .DW(SEC_DW)
  ) u_mem (
    .mclk(mclk),
    .we(sec_wr_en),
    .waddr(sec_wr_addr),
    .wdata(sec_wr_data),
    .raddr({r_q.sel, r_q.byte_a}),
    .rdata(rdata)
  );

  // Edge detection on the synchronised serial clock.
  assign rise = sclk_s & ~r_q.sclk_p;
  assign fall = ~sclk_s & r_q.sclk_p;
  assign addr_full = {r_q.sh[22:0], si_s};

  // Status registers are locked by the power-supply lock or by hardware protect.
  assign locked = status_protect_high | (status_protect_low & ~wp_n_s); // RL15
  assign commit_ok = write_enable_latch & ~locked & ~suspend & ~r_q.busy; // RL22 RL16 RL9

  // Check address clipped to the array and turned into a sector number.
  assign amax = LARGE ? AMAX_LG : AMAX_SM; // RL19
  assign ca = chk_addr & amax; // RL19
  always_comb begin
    sec = ca[22:12];
    if (chk_block_erase) begin
      sec[3:0] = top_bottom_select ? 4'h0 : 4'hf; // RL18
    end
  end

  // Next-state logic for the whole block.
  always_comb begin
    r_d = r_q;
    r_d.sclk_p = sclk_s;
    r_d.wel_clr = 1'b0;
    r_d.nv_wr = 1'b0;
    r_d.pend = {r_q.pend[0], 1'b0};

    // Self-timed pointer write keeps busy high until the count runs out.
    if (r_q.prog != 16'h0000) begin
      r_d.prog = r_q.prog - 16'h0001;
    end

    // Memory read data is one cycle behind an address change.
    if (r_q.pend[1]) begin
      r_d.tx = rdata;
    end

    // Protection verdict for the check port, from the stored pointer word.
    if (r_q.ptr[PF_MODE]) begin
      r_d.prot = blk_protect; // RL10
    end else if (r_q.ptr[PF_ALL]) begin
      r_d.prot = 1'b1; // RL12
    end else begin
      r_d.prot = beyond(sec, r_q.ptr[PF_SEC_MSB:PF_SEC_LSB], top_bottom_select); // RL13 RL18 RL23
    end

    // The kept pointer is restored once after reset release.
    if (r_q.boot) begin
      r_d.boot = 1'b0;
      r_d.ptr = ptr_mask(nv_ptr); // RL23
    end

    if (cs_n_s) begin
      // A fully clocked 39h takes effect only when chip select rises.
      if (r_q.st == S_HOLD && commit_ok) begin
        r_d.ptr = ptr_mask(r_q.sh[23:ADDR_PTR_LSB]); // RL10 RL11 RL23
        r_d.nv_wr = 1'b1; // RL23
        r_d.wel_clr = 1'b1;
        r_d.prog = PROG_CYCLES; // RL21
      end
      r_d.st = S_IDLE; // RL6
      r_d.cnt = 5'h00;
    end else begin
      unique case (r_q.st)
        S_IDLE, S_CMD: begin
          r_d.st = S_CMD;
          if (rise) begin
            r_d.sh = addr_full; // RL2
            r_d.cnt = r_q.cnt + 5'h01;
            if (r_q.cnt == OP_LAST) begin
              r_d.op = addr_full[7:0];
              r_d.cnt = 5'h00;
              if (addr_full[7:0] == OP_RDSEC && !r_q.busy) begin
                r_d.st = S_ADDR; // RL7
              end else if (addr_full[7:0] == OP_SETP) begin
                r_d.st = S_ADDR;
              end else if (addr_full[7:0] == OP_RDS3) begin
                r_d.st = S_STAT;
                r_d.sb = 2'h0;
                r_d.tx = status_reg_three; // RL17
              end else begin
                r_d.st = S_SKIP; // RL7
              end
            end
          end
        end
        S_ADDR: begin
          if (rise) begin
            r_d.sh = addr_full; // RL2
            r_d.cnt = r_q.cnt + 5'h01;
            if (r_q.cnt == ADDR_LAST) begin
              r_d.cnt = 5'h00;
              if (r_q.op == OP_RDSEC) begin
                r_d.st = S_DUMMY;
                r_d.sel = sec_sel(addr_full); // RL8 RL4
                r_d.byte_a = addr_full[7:0]; // RL8
              end else begin
                r_d.st = S_HOLD;
              end
            end
          end
        end
        S_DUMMY: begin
          if (rise) begin
            r_d.cnt = r_q.cnt + 5'h01;
            if (r_q.cnt == DUMMY_LAST) begin
              r_d.cnt = 5'h00;
              r_d.st = S_DATA; // RL3
              r_d.pend = 2'h1;
            end
          end
        end
        S_DATA: begin
          if (fall) begin
            r_d.so = r_q.tx[7]; // RL3
            r_d.tx = {r_q.tx[6:0], 1'b1};
            r_d.cnt = r_q.cnt + 5'h01;
            if (r_q.cnt[2:0] == BIT_LAST) begin
              r_d.cnt = 5'h00;
              r_d.byte_a = r_q.byte_a + 8'h01; // RL5
              r_d.pend = 2'h1;
            end
          end
        end
        S_STAT: begin
          if (fall) begin
            r_d.so = r_q.tx[7]; // RL3
            r_d.tx = {r_q.tx[6:0], 1'b1};
            r_d.cnt = r_q.cnt + 5'h01;
            if (r_q.cnt[2:0] == BIT_LAST) begin
              r_d.cnt = 5'h00;
              // Bytes past the pointer low byte are undefined; ones are sent.
              unique case (r_q.sb)
                2'h0: r_d.tx = r_q.ptr[13:6]; // RL17
                2'h1: r_d.tx = {r_q.ptr[5:0], 2'h0}; // RL17
                default: r_d.tx = ERASED;
              endcase
              if (r_q.sb != 2'h3) begin
                r_d.sb = r_q.sb + 2'h1;
              end
            end
          end
        end
        S_HOLD: begin
          // Extra clocks after the address spoil the 39h command.
          if (rise) begin
            r_d.st = S_SKIP;
          end
        end
        S_SKIP: begin
          r_d.st = S_SKIP;
        end
      endcase
    end

    // Busy is judged after a commit so the write cycle shows from its first edge.
    r_d.busy = busy_in | (r_d.prog != 16'h0000); // RL21

    // Output is driven only while a read phase owns the line.
    r_d.oe_n = ~(r_d.st == S_DATA || r_d.st == S_STAT); // RL6
  end

  // Single state register for the block.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r_q <= REG_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // Every output below comes straight from a flop.
  assign so = r_q.so;
  assign so_oe_n = r_q.oe_n;
  assign chk_protected = r_q.prot;
  assign ptr_word = r_q.ptr;
  assign nv_wr = r_q.nv_wr;
  assign wel_clr = r_q.wel_clr;
  assign busy = r_q.busy;

endmodule

`default_nettype wire

// ### test/srp_host.sv
`timescale 1ns/10ps
`default_nettype none

// Host model; its link clock stands still between frames.
module srp_host (
  input wire logic mclk,
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  logic [7:0] rb = 8'h00;
  logic drv = 1'b0;
  event got;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // Half a link period is six system cycles, giving the 48 ns link clock.
  task automatic half();
    repeat (6) @(posedge mclk);
    #1;
  endtask

  // Shifts nb bits of w from the top, nd dummy clocks, then gathers nr bytes.
  task automatic xfer(input logic [39:0] w, input int nb, input int nd, input int nr);
    @(posedge mclk);
    #1;
    cs_n = 1'b0;
    half();
    for (int i = 0; i < nb + nd + 8 * nr; i++) begin
      sclk = 1'b0;
      si = (i < nb) ? w[39 - i] : ~si;
      half();
      drv = drv | ~so_oe_n;
      if (i >= nb + nd) rb = {rb[6:0], so};
      if (i >= nb + nd && (i - nb - nd) % 8 == 7) ->got;
      sclk = 1'b1;
      half();
    end
    sclk = 1'b0;
    half();
    // The data line toggles once released, so stale bits never pass for driven ones.
    cs_n = 1'b1;
    si = ~si;
    // A second half lets the self-timed write after a 39h end inside this frame.
    half();
    half();
  endtask
endmodule

`default_nettype wire

// ### test/srp_chk.sv
`timescale 1ns/10ps
`default_nettype none

// Port checker for the pointer store, its verdicts and the serial output.
module srp_chk
  import srp_pkg::*;
#(
  parameter logic LARGE = 1'b1,
  parameter logic [15:0] PROG_CYCLES = 16'h0004
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic so_oe_n,
  input wire logic busy_in,
  input wire logic suspend,
  input wire logic write_enable_latch,
  input wire logic top_bottom_select,
  input wire logic blk_protect,
  input wire logic [23:0] chk_addr,
  input wire logic chk_block_erase,
  input wire logic chk_protected,
  input wire logic [13:0] ptr_word,
  input wire logic nv_wr,
  input wire logic wel_clr
);
  logic [10:0] s_w;
  logic [10:0] p_w;
  logic pm_w;
  logic v_w;

  // Expected pointer verdict; a block erase judges the block's far sector.
  assign s_w = chk_block_erase ? {chk_addr[22:16], {4{~top_bottom_select}}} : chk_addr[22:12];
  assign p_w = ptr_word[PF_SEC_MSB:PF_SEC_LSB];
  assign pm_w = !ptr_word[PF_MODE] && !ptr_word[PF_ALL];
  assign v_w = top_bottom_select ? (s_w < p_w) : (s_w > p_w);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_wel_gates_write: assert property (nv_wr |-> wel_clr && $past(write_enable_latch))
    else $error("pointer write without enable");
  a_susp_no_write: assert property (suspend && $past(suspend, 8) |-> !nv_wr)
    else $error("pointer write in suspend");
  a_ptr_only_write: assert property ($changed(ptr_word) |-> nv_wr || !$past(nrst, 2))
    else $error("pointer changed unasked");
  a_block_mode: assert property (ptr_word[PF_MODE] |=> chk_protected == $past(blk_protect))
    else $error("block mode verdict wrong");
  a_all_protect: assert property (!ptr_word[PF_MODE] && ptr_word[PF_ALL] |=> chk_protected)
    else $error("all-protect verdict wrong");
  a_sector_dir: assert property (pm_w && !chk_block_erase |=> chk_protected == $past(v_w))
    else $error("sector verdict wrong");
  a_block_erase: assert property (pm_w && chk_block_erase |=> chk_protected == $past(v_w))
    else $error("erase verdict wrong");
  a_idle_release: assert property (cs_n [*8] |-> so_oe_n)
    else $error("output driven while deselected");
  a_busy_read_off: assert property (busy_in && $past(busy_in, 8) |-> so_oe_n)
    else $error("read answered while busy");

  c_ptr_write: cover property (nv_wr);
  c_read_drive: cover property ($fell(so_oe_n));
  c_erase_pass: cover property (pm_w && chk_block_erase ##1 !chk_protected);
endmodule

bind srp_top srp_chk #(.LARGE(LARGE), .PROG_CYCLES(PROG_CYCLES)) u_chk (.*);

`default_nettype wire

// ### test/srp_top_bench.sv
`timescale 1ns/10ps
`default_nettype none

// Self-checking bench: host frames on the link plus the protection check port.
module srp_top_bench
  import srp_pkg::*;
;
  logic mclk = 1'b0, nrst = 1'b0, wp_n = 1'b1, busy_in = 1'b0, suspend = 1'b0;
  logic write_enable_latch = 1'b1, status_protect_low = 1'b0, status_protect_high = 1'b0;
  logic top_bottom_select = 1'b0, blk_protect = 1'b0, chk_block_erase = 1'b0, sec_wr_en = 1'b0;
  logic cs_n, sclk, si, so, so_oe_n, chk_protected, nv_wr, wel_clr, busy;
  logic [7:0] status_reg_three = 8'h00;
  logic [SEC_DW-1:0] sec_wr_data = 8'h00;
  logic [SEC_AW-1:0] sec_wr_addr = 10'h000;
  logic [23:0] chk_addr = 24'h000000;
  logic [23:0] a, x;
  logic [13:0] nv_ptr = 14'h0001;
  logic [13:0] ptr_word, e;
  logic [31:0] seed = 32'hc9705220;
  logic [31:0] r;
  logic [7:0] exq[$];
  int fails = 0, checks = 0, cyc = 0, nwr = 0, n0, nbz = 0, nb0;

  srp_top #(.LARGE(1'b1), .PROG_CYCLES(16'h0004)) dut (.*);
  srp_host host (.*);

  initial begin
    forever #2 mclk = ~mclk;
  end

  // Shift register stimulus; the fixed start keeps every run alike.
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Verdict from the pointer word the bench wrote; erase judges the block's far sector.
  function automatic logic pexp(input logic [23:0] v, input logic be, input logic [13:0] p);
    logic [10:0] s;
    s = be ? {v[22:16], {4{~top_bottom_select}}} : v[22:12];
    if (p[0]) return blk_protect;
    if (p[1]) return 1'b1;
    return top_bottom_select ? (s < p[12:2]) : (s > p[12:2]);
  endfunction

  task automatic pchk(input logic [23:0] v, input logic be);
    chk_addr = v;
    chk_block_erase = be;
    @(posedge mclk);
    #1;
    chk("verdict", 24'(chk_protected), 24'(pexp(v, be, e)));
  endtask

  // Each byte the host gathers is matched with the oldest expectation.
  always @(host.got) begin
    if (exq.size() == 0) chk("extra byte", 24'h000001, 24'h000000);
    else chk("byte", 24'(host.rb), 24'(exq.pop_front()));
  end

  // Counts pointer writes and cuts a hang short.
  always @(posedge mclk) begin
    cyc++;
    if (nv_wr === 1'b1) nwr++;
    if (busy === 1'b1) nbz++;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    r = rnd();
    nv_ptr = {1'b1, r[12:0]};
    repeat (4) @(posedge mclk);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk("boot pointer", 24'(ptr_word), {10'h000, 1'b0, r[12:0]});
    // Register one bytes FE, FF and 00 get data, byte 01 stays erased, so the read wraps.
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      sec_wr_en = 1'b1;
      sec_wr_addr = {2'b01, 8'hfe + 8'(i)};
      sec_wr_data = r[7:0];
      exq.push_back(r[7:0]);
      @(posedge mclk);
      #1;
    end
    sec_wr_en = 1'b0;
    exq.push_back(8'hff);
    host.xfer({OP_RDSEC, 24'h0010fe, 8'h00}, 32, 8, 4);
    exq.push_back(8'hff);
    host.xfer({OP_RDSEC, 24'h0030a5, 8'h00}, 32, 8, 1);
    busy_in = 1'b1;
    host.drv = 1'b0;
    host.xfer({OP_RDSEC, 24'h001000, 8'h00}, 32, 24, 0);
    chk("busy read", 24'(host.drv), 24'h000000);
    // Each pass shuts one gate on the pointer write; pass five is open, pass six clocks one bit too many.
    for (int i = 0; i < 7; i++) begin
      write_enable_latch = (i != 0);
      status_protect_high = (i == 1);
      status_protect_low = (i == 2);
      wp_n = (i != 2);
      suspend = (i == 3);
      busy_in = (i == 4);
      n0 = nwr;
      host.xfer({OP_SETP, 24'h000000, 8'h00}, 32 + (i == 6), 0, 0);
      chk("gated write", 24'(nwr - n0), 24'(i == 5));
    end
    // Pointer at block top, bottom and middle, then all-protect, then block mode.
    for (int k = 0; k < 5; k++) begin
      r = rnd();
      a = {r[23:16], (k == 1) ? 4'h0 : (k == 2) ? 4'h7 : 4'hf, k == 3, k == 4, r[9:0]};
      top_bottom_select = (k == 1);
      e = {1'b0, a[22:10]};
      n0 = nwr;
      nb0 = nbz;
      host.xfer({OP_SETP, a, 8'h00}, 32, 0, 0);
      chk("pointer write", 24'(nwr - n0), 24'h000001);
      chk("busy cycles", 24'(nbz - nb0), 24'h000004);
      chk("pointer word", 24'(ptr_word), 24'(e));
      status_reg_three = r[31:24];
      exq.push_back(r[31:24]);
      exq.push_back(e[13:6]);
      exq.push_back({e[5:0], 2'b00});
      host.xfer({OP_RDS3, 32'h00000000}, 8, 0, 3);
      for (int j = 0; j < 5; j++) begin
        blk_protect = r[j];
        x = a + ((j == 1) ? 24'h001000 : (j == 2) ? 24'hfff000 : (j == 4) ? 24'h010000 : 24'h000000);
        pchk(x & 24'h7fffff, j > 2);
      end
    end
    end_sim();
  end
endmodule

`default_nettype wire
